//--- src/ts_reply_pkg.sv
// Constants and types shared by the timestamp-read responder files
package ts_reply_pkg;
  // ==========================================
  // Clock and lap units
  localparam int CLK_PERIOD_NS = 20; // Graphics clock period, 50 MHz
  localparam int QNS_PER_NS = 4; // Lap unit is a quarter nanosecond
  localparam int HIGH_LSB_NS = 1024; // One high-dword step, 1.024 us
  localparam int LAP_W = 64; // Full lap span, wraps freely
  localparam int LOW_W = $clog2(HIGH_LSB_NS * QNS_PER_NS); // Low field width
  localparam int HIGH_W = 32; // High field width
  // Quarter nanoseconds per graphics clock
  localparam logic [LAP_W-1:0] LAP_STEP = LAP_W'(CLK_PERIOD_NS * QNS_PER_NS);
  // ==========================================
  // Message and reply layout
  localparam int PAYLOAD_W = 256; // Request payload width
  localparam int DWORD_W = 32; // One dword
  localparam int HALF_W = 128; // Half of the destination register
  localparam int BYTE_EN_W = 32; // One enable per destination byte
  localparam int HALF_BYTES = 16; // Bytes in one half
  localparam int SEL_POS = 5 * DWORD_W + 31; // Upper-half select, dword 5 bit 31
  localparam int LOW_FIELD_LSB = 20; // Low field sits in bits 31:20
  localparam int MBZ_W = 20; // Zero bits under each low field
  localparam logic [BYTE_EN_W-1:0] LOWER_EN = 32'h0000_FFFF; // Lower half enables
  localparam logic [BYTE_EN_W-1:0] UPPER_EN = 32'hFFFF_0000; // Upper half enables
  // ==========================================
  // APB register map
  localparam int ADDR_W = 8; // Byte address width
  localparam logic [ADDR_W-1:0] REG_CONTROL = 8'h00; // Run and strobes
  localparam logic [ADDR_W-1:0] REG_SAVE_LO = 8'h04; // Saved lap, low word
  localparam logic [ADDR_W-1:0] REG_SAVE_HI = 8'h08; // Saved lap, high word
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h0C; // Busy and counts
  localparam logic [ADDR_W-1:0] REG_WALL_LO = 8'h10; // Live wall clock, low word
  localparam logic [ADDR_W-1:0] REG_WALL_HI = 8'h14; // Live wall clock, high word
  localparam int CTL_RUN_BIT = 0; // Context running
  localparam int CTL_SAVE_BIT = 1; // Write 1: save context lap
  localparam int CTL_RESTORE_BIT = 2; // Write 1: restore context lap
  localparam int STAT_BUSY_BIT = 0; // Reply in progress
  localparam int STAT_DROP_LSB = 8; // Requests without reply
  localparam int DROP_W = 8;
  localparam int STAT_SERV_LSB = 16; // Replies delivered
  localparam int SERV_W = 16;
  // ==========================================
  // Responder states, Gray along idle-capture-reply
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CAPTURE = 2'h1,
    ST_REPLY = 2'h3
  } fsm_t;
endpackage : ts_reply_pkg

//--- src/reply_fmt_if.sv
// Interface between the responder and its reply formatter
`timescale 1ns/100ps
`default_nettype none
interface reply_fmt_if;
  logic [ts_reply_pkg::LAP_W-1:0] wallLap; // Wall-clock snapshot
  logic [ts_reply_pkg::LAP_W-1:0] ctxLap; // Context lap snapshot
  logic upperHalf; // Reply goes to upper half
  logic [ts_reply_pkg::PAYLOAD_W-1:0] data; // Formatted reply
  logic [ts_reply_pkg::BYTE_EN_W-1:0] byteEn; // Byte write enables
  modport responder(output wallLap, output ctxLap, output upperHalf, input data, input byteEn);
  modport formatter(input wallLap, input ctxLap, input upperHalf, output data, output byteEn);
endinterface : reply_fmt_if
`default_nettype wire

//--- src/lap_counter.sv
// Per-context lap counter with restore load
`timescale 1ns/100ps
`default_nettype none
module lap_counter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic countEn,
  input wire logic loadEn,
  input wire logic [ts_reply_pkg::LAP_W-1:0] loadValue,
  output logic [ts_reply_pkg::LAP_W-1:0] lapValue
);
  // ==========================================
  // State
  typedef struct packed {
    logic [ts_reply_pkg::LAP_W-1:0] lap; // Quarter-ns count
  } ctr_state_t;
  ctr_state_t state_q; // Registered state
  ctr_state_t state_d; // Next state
  // Restore wins over counting so a reload is exact
  always_comb
  begin
    state_d = state_q;
    if (loadEn)
      state_d.lap = loadValue; // [RQ5]
    else if (countEn)
      state_d.lap = state_q.lap + ts_reply_pkg::LAP_STEP; // [RQ4] [RQ16]
  end
  // Register the state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= '0;
    else
      state_q <= state_d;
  end
  assign lapValue = state_q.lap;
  // ==========================================
  // Checks
  AST_CTX_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ4]
    countEn && !loadEn |=> lapValue == $past(lapValue) + ts_reply_pkg::LAP_STEP)
    else $error("Context lap did not advance by one clock");
  AST_CTX_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    !countEn && !loadEn |=> $stable(lapValue))
    else $error("Context lap moved while switched out");
  AST_CTX_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RQ5]
    loadEn |=> lapValue == $past(loadValue))
    else $error("Context lap restore failed");
endmodule : lap_counter
`default_nettype wire

//--- src/reply_formatter.sv
// Packs two lap snapshots into one half of a 256-bit reply
`timescale 1ns/100ps
`default_nettype none
module reply_formatter (
  reply_fmt_if.formatter fmt
);
  // ==========================================
  // Half packing: ctx high, ctx low, zeros, wall high, wall low, zeros
  function automatic logic [ts_reply_pkg::HALF_W-1:0] packHalf(
    input logic [ts_reply_pkg::LAP_W-1:0] wall,
    input logic [ts_reply_pkg::LAP_W-1:0] ctx
  );
    packHalf = {ctx[ts_reply_pkg::LOW_W +: ts_reply_pkg::HIGH_W], ctx[ts_reply_pkg::LOW_W-1:0],
                {ts_reply_pkg::MBZ_W{1'b0}},
                wall[ts_reply_pkg::LOW_W +: ts_reply_pkg::HIGH_W], wall[ts_reply_pkg::LOW_W-1:0],
                {ts_reply_pkg::MBZ_W{1'b0}}};
  endfunction : packHalf
  logic [ts_reply_pkg::HALF_W-1:0] half; // Packed reply half
  assign half = packHalf(fmt.wallLap, fmt.ctxLap);
  // Unselected half is zero; its enables are off anyway
  assign fmt.data = fmt.upperHalf ? {half, {ts_reply_pkg::HALF_W{1'b0}}}
                                  : {{ts_reply_pkg::HALF_W{1'b0}}, half};
  // ==========================================
  // One enable per byte, set only in the chosen half
  for (genvar gb = 0; gb < ts_reply_pkg::BYTE_EN_W; gb++)
  begin : g_byteEn
    assign fmt.byteEn[gb] = fmt.upperHalf ? (gb >= ts_reply_pkg::HALF_BYTES)
                                          : (gb < ts_reply_pkg::HALF_BYTES);
  end
endmodule : reply_formatter
`default_nettype wire

//--- src/ts_read_responder.sv
// Timestamp-read responder: request port, lap snapshot, reply and APB registers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// [RQ1] Each request is one 256-bit payload
// [RQ2] Wall lap ignores context and clock changes
// [RQ3] Wall lap is the shared device timestamp
// [RQ4] Context lap counts clocks while running
// [RQ5] Context lap saved and restored on switches
// [RQ6] Payload dword 5 bit 31 picks half
// [RQ7] Spawn tag bits are ignored
// [RQ8] Requester sends spawn tag only when required
// [RQ9] Reply only when reply flag is set
// [RQ10] Requester always sets the reply flag
// [RQ11] Only selected half written, via enables
// [RQ12] Lower half: dwords 3..0 layout, zeros
// [RQ13] Upper half: dwords 7..4 layout, zeros
// [RQ14] High dword step is 1.024 us
// [RQ15] Low field step is quarter nanosecond
// [RQ16] Laps wrap freely over 64 bits
// [RQ17] Requester keeps reserved bits zero
// [RQ18] High and low parts sampled together
module ts_read_responder (
  input wire logic sys_clk, // Graphics clock
  input wire logic rst_b, // Async reset, active low
  // APB slave
  input wire logic psel, // Slave select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write when high
  input wire logic [ts_reply_pkg::ADDR_W-1:0] paddr, // Byte address
  input wire logic [31:0] pwdata, // Write data
  output logic [31:0] prdata, // Read data
  output logic pready, // Transfer done
  output logic pslverr, // Unmapped address
  // Device-wide timestamp, quarter-ns units
  input wire logic [ts_reply_pkg::LAP_W-1:0] wallclockIn,
  // Request from a thread
  input wire logic reqValid, // Request offered
  input wire logic [ts_reply_pkg::PAYLOAD_W-1:0] reqPayload, // Message payload
  input wire logic reqReplyWanted, // Descriptor reply flag
  output logic reqReady, // Request can be taken
  // Reply to the thread register file
  output logic replyValid, // Reply held
  output logic [ts_reply_pkg::PAYLOAD_W-1:0] replyData, // Reply register image
  output logic [ts_reply_pkg::BYTE_EN_W-1:0] replyByteEn, // Byte write enables
  input wire logic replyReady // Reply consumed
);
  // ==========================================
  // State
  typedef struct packed {
    ts_reply_pkg::fsm_t fsm; // Responder state
    logic reqReady; // Request port open
    logic upper; // Captured half select
    logic [ts_reply_pkg::LAP_W-1:0] wallSnap; // Wall-clock snapshot
    logic [ts_reply_pkg::LAP_W-1:0] ctxSnap; // Context lap snapshot
    logic replyValid; // Reply pending
    logic [ts_reply_pkg::PAYLOAD_W-1:0] replyData; // Reply image
    logic [ts_reply_pkg::BYTE_EN_W-1:0] replyByteEn; // Reply enables
    logic ctlRun; // Context running
    logic saveStrobe; // Save pulse
    logic restoreStrobe; // Restore pulse
    logic [ts_reply_pkg::LAP_W-1:0] saveVal; // Saved context lap
    logic [ts_reply_pkg::SERV_W-1:0] served; // Replies delivered
    logic [ts_reply_pkg::DROP_W-1:0] dropped; // Requests without reply
    logic pready; // APB ready
    logic pslverr; // APB error
    logic [31:0] prdata; // APB read data
  } resp_state_t;
  resp_state_t state_q; // Registered state
  resp_state_t state_d; // Next state
  logic apbAccess; // APB access phase
  logic take; // Request accepted this cycle
  logic [ts_reply_pkg::LAP_W-1:0] ctxLap; // Live context lap
  reply_fmt_if fmtBus(); // Link to the formatter
  assign apbAccess = psel && penable;
  assign take = (state_q.fsm == ts_reply_pkg::ST_IDLE) && reqValid && state_q.reqReady;
  // ==========================================
  // Register decode, shared by error and write paths
  function automatic logic regHit(input logic [ts_reply_pkg::ADDR_W-1:0] addr);
    case (addr)
      ts_reply_pkg::REG_CONTROL,
      ts_reply_pkg::REG_SAVE_LO,
      ts_reply_pkg::REG_SAVE_HI,
      ts_reply_pkg::REG_STATUS,
      ts_reply_pkg::REG_WALL_LO,
      ts_reply_pkg::REG_WALL_HI: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  endfunction : regHit
  // Read mux; wall words are live, so a two-read value may tear
  function automatic logic [31:0] readWord(input logic [ts_reply_pkg::ADDR_W-1:0] addr);
    readWord = 32'h0000_0000;
    case (addr)
      ts_reply_pkg::REG_CONTROL: readWord[ts_reply_pkg::CTL_RUN_BIT] = state_q.ctlRun;
      ts_reply_pkg::REG_SAVE_LO: readWord = state_q.saveVal[31:0];
      ts_reply_pkg::REG_SAVE_HI: readWord = state_q.saveVal[63:32];
      ts_reply_pkg::REG_STATUS:
      begin
        readWord[ts_reply_pkg::STAT_BUSY_BIT] = (state_q.fsm != ts_reply_pkg::ST_IDLE);
        readWord[ts_reply_pkg::STAT_DROP_LSB +: ts_reply_pkg::DROP_W] = state_q.dropped;
        readWord[ts_reply_pkg::STAT_SERV_LSB +: ts_reply_pkg::SERV_W] = state_q.served;
      end
      ts_reply_pkg::REG_WALL_LO: readWord = wallclockIn[31:0];
      ts_reply_pkg::REG_WALL_HI: readWord = wallclockIn[63:32];
      default: readWord = 32'h0000_0000; // Unmapped reads zero
    endcase
  endfunction : readWord
  // ==========================================
  // Next-state logic: APB slave, save/restore, request sequencer
  always_comb
  begin
    state_d = state_q;
    state_d.saveStrobe = 1'b0; // Strobes last one cycle
    state_d.restoreStrobe = 1'b0;
    state_d.pready = 1'b0;
    state_d.pslverr = 1'b0;
    // Answer one cycle into the access phase
    if (apbAccess && !state_q.pready)
    begin
      state_d.pready = 1'b1;
      state_d.pslverr = !regHit(paddr);
      state_d.prdata = readWord(paddr);
    end
    // Writes land only on the completing edge
    if (apbAccess && state_q.pready && pwrite && regHit(paddr))
    begin
      case (paddr)
        ts_reply_pkg::REG_CONTROL:
        begin
          state_d.ctlRun = pwdata[ts_reply_pkg::CTL_RUN_BIT]; // [RQ4]
          state_d.saveStrobe = pwdata[ts_reply_pkg::CTL_SAVE_BIT]; // [RQ5]
          state_d.restoreStrobe = pwdata[ts_reply_pkg::CTL_RESTORE_BIT]; // [RQ5]
        end
        ts_reply_pkg::REG_SAVE_LO: state_d.saveVal[31:0] = pwdata;
        ts_reply_pkg::REG_SAVE_HI: state_d.saveVal[63:32] = pwdata;
        default: state_d.saveVal = state_q.saveVal; // Read-only words
      endcase
    end
    // Hardware save overrides a software write in the same cycle
    if (state_q.saveStrobe)
      state_d.saveVal = ctxLap; // [RQ5]
    // Request sequencer
    case (state_q.fsm)
      ts_reply_pkg::ST_IDLE:
      begin
        state_d.reqReady = 1'b1;
        if (take)
        begin
          // Both laps caught whole in one cycle; spawn tag is not looked at
          state_d.wallSnap = wallclockIn; // [RQ2] [RQ3] [RQ18] [RQ7]
          state_d.ctxSnap = ctxLap; // [RQ18]
          state_d.upper = reqPayload[ts_reply_pkg::SEL_POS]; // [RQ6]
          if (reqReplyWanted)
          begin
            state_d.fsm = ts_reply_pkg::ST_CAPTURE; // [RQ9]
            state_d.reqReady = 1'b0; // [RQ1]
          end
          else
            state_d.dropped = state_q.dropped + 1'b1; // [RQ9]
        end
      end
      ts_reply_pkg::ST_CAPTURE:
      begin
        // Formatter output registered so the reply ports come from flops
        state_d.replyData = fmtBus.data; // [RQ12] [RQ13]
        state_d.replyByteEn = fmtBus.byteEn; // [RQ11]
        state_d.replyValid = 1'b1;
        state_d.fsm = ts_reply_pkg::ST_REPLY;
      end
      ts_reply_pkg::ST_REPLY:
      begin
        // Held until the register file takes it
        if (replyReady)
        begin
          state_d.replyValid = 1'b0;
          state_d.reqReady = 1'b1;
          state_d.served = state_q.served + 1'b1;
          state_d.fsm = ts_reply_pkg::ST_IDLE;
        end
      end
      default:
      begin
        // Illegal code: drop back to idle
        state_d.fsm = ts_reply_pkg::ST_IDLE;
        state_d.replyValid = 1'b0;
        state_d.reqReady = 1'b0;
      end
    endcase
  end
  // Register the state
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= '0;
    else
      state_q <= state_d;
  end
  // ==========================================
  // Context lap counter and reply formatter
  lap_counter ctxCounter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .countEn(state_q.ctlRun),
    .loadEn(state_q.restoreStrobe),
    .loadValue(state_q.saveVal),
    .lapValue(ctxLap)
  );
  assign fmtBus.wallLap = state_q.wallSnap;
  assign fmtBus.ctxLap = state_q.ctxSnap;
  assign fmtBus.upperHalf = state_q.upper;
  reply_formatter fmtUnit (
    .fmt(fmtBus.formatter)
  );
  // ==========================================
  // Outputs, all from flops
  assign prdata = state_q.prdata;
  assign pready = state_q.pready;
  assign pslverr = state_q.pslverr;
  assign reqReady = state_q.reqReady;
  assign replyValid = state_q.replyValid;
  assign replyData = state_q.replyData;
  assign replyByteEn = state_q.replyByteEn;
  // ==========================================
  // Checks
  logic [ts_reply_pkg::HALF_W-1:0] halfOut; // Selected reply half
  logic [ts_reply_pkg::HALF_W-1:0] halfOff; // Unselected reply half
  assign halfOut = state_q.upper ? replyData[ts_reply_pkg::HALF_W +: ts_reply_pkg::HALF_W]
                                 : replyData[ts_reply_pkg::HALF_W-1:0];
  assign halfOff = state_q.upper ? replyData[ts_reply_pkg::HALF_W-1:0]
                                 : replyData[ts_reply_pkg::HALF_W +: ts_reply_pkg::HALF_W];
  default clocking cbAst @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  sequence seqTakeWant;
    take && reqReplyWanted;
  endsequence
  sequence seqReplyRise;
    !replyValid ##1 replyValid;
  endsequence
  AST_ACK_REPLY: assert property (seqTakeWant |=> seqReplyRise) // [RQ9]
    else $error("Wanted reply not raised two cycles after request");
  AST_NO_ACK: assert property (take && !reqReplyWanted |=> !replyValid [*2]) // [RQ9]
    else $error("Reply produced without reply flag");
  AST_ONE_PAYLOAD: assert property (seqTakeWant |=> !reqReady [*2]) // [RQ1]
    else $error("Second payload taken before reply");
  AST_HALF_EN: assert property (seqTakeWant |-> ##2 // [RQ6] [RQ11]
    replyByteEn == ($past(reqPayload[ts_reply_pkg::SEL_POS], 2) ? ts_reply_pkg::UPPER_EN
                                                                 : ts_reply_pkg::LOWER_EN))
    else $error("Byte enables do not match half select");
  AST_WALL_FIELDS: assert property (seqTakeWant |-> ##2 // [RQ3] [RQ14] [RQ15] [RQ18]
    {halfOut[ts_reply_pkg::DWORD_W +: ts_reply_pkg::HIGH_W],
     halfOut[ts_reply_pkg::LOW_FIELD_LSB +: ts_reply_pkg::LOW_W]}
      == $past(wallclockIn[ts_reply_pkg::LOW_W + ts_reply_pkg::HIGH_W - 1:0], 2))
    else $error("Wall lap fields wrong or torn");
  AST_CTX_FIELDS: assert property (seqTakeWant |-> ##2 // [RQ4] [RQ18]
    {halfOut[3 * ts_reply_pkg::DWORD_W +: ts_reply_pkg::HIGH_W],
     halfOut[2 * ts_reply_pkg::DWORD_W + ts_reply_pkg::LOW_FIELD_LSB +: ts_reply_pkg::LOW_W]}
      == $past(ctxLap[ts_reply_pkg::LOW_W + ts_reply_pkg::HIGH_W - 1:0], 2))
    else $error("Context lap fields wrong or torn");
  AST_MBZ: assert property (replyValid |-> // [RQ12] [RQ13]
    halfOut[ts_reply_pkg::MBZ_W-1:0] == '0 &&
    halfOut[2 * ts_reply_pkg::DWORD_W +: ts_reply_pkg::MBZ_W] == '0 && halfOff == '0)
    else $error("Zero fields of reply not zero");
  AST_APB_WAIT: assert property (apbAccess && !pready |=> pready)
    else $error("APB answer not given one cycle into access");
  AST_REPLY_HOLD: assert property (replyValid && !replyReady |=> replyValid && $stable(replyData)) // [RQ11]
    else $error("Reply dropped before it was taken");
endmodule : ts_read_responder
`default_nettype wire

//--- tb/thread_model.sv
// Requesting thread model: offers timestamp requests and consumes the replies
`timescale 1ns/100ps
`default_nettype none
module thread_model (
  input wire logic sys_clk,
  input wire logic reqReady,
  input wire logic replyValid,
  input wire logic [255:0] replyData,
  input wire logic [31:0] replyByteEn,
  input wire logic [63:0] wallclockIn,
  output logic reqValid,
  output logic [255:0] reqPayload,
  output logic reqReplyWanted,
  output logic replyReady
);
  // ==========================================
  // Capture of the last exchange
  logic [255:0] gotData; // Reply image at consume edge
  logic [31:0] gotEn; // Enables at consume edge
  logic [63:0] takeWall; // Wall clock seen at the take edge
  logic gotReply; // A reply showed up
  logic busyLeak; // Ready seen while a reply was pending
  int takeCycle; // Cycle number of the take
  int cyc; // Free-running cycle count
  initial
  begin
    reqValid = 1'b0;
    reqPayload = '0;
    reqReplyWanted = 1'b0;
    replyReady = 1'b0;
    cyc = 0;
  end
  // Cycle count, used for lap differences
  always @(posedge sys_clk) cyc <= cyc + 1;
  // ==========================================
  // One request; stall holds off the consume strobe
  task automatic send(input logic up, input logic wanted, input int stall, output logic ok);
    int n;
    n = 0;
    gotReply = 1'b0;
    busyLeak = 1'b0;
    @(posedge sys_clk);
    reqValid <= 1'b1;
    // Reserved dwords zero, spawn tag filler, ignored dwords patterned
    reqPayload <= {64'h0, up, 23'h0, 8'hA5, {5{32'hC3C3_3C3C}}};
    reqReplyWanted <= wanted;
    do @(posedge sys_clk); while (reqReady !== 1'b1 && ++n < 50);
    takeWall = wallclockIn;
    takeCycle = cyc;
    reqValid <= 1'b0;
    // Released payload shows the inverse, never the old value
    reqPayload <= ~reqPayload;
    for (int i = 0; i < 8 && !wanted; i++)
    begin
      @(posedge sys_clk);
      if (replyValid === 1'b1) gotReply = 1'b1;
    end
    if (wanted)
    begin
      do @(posedge sys_clk); while (replyValid !== 1'b1 && ++n < 50);
      repeat (stall)
      begin
        @(posedge sys_clk);
        if (reqReady === 1'b1) busyLeak = 1'b1;
      end
      replyReady <= 1'b1;
      @(posedge sys_clk);
      gotReply = replyValid;
      gotData = replyData;
      gotEn = replyByteEn;
      replyReady <= 1'b0;
    end
    ok = (n < 50);
  endtask : send
endmodule : thread_model
`default_nettype wire

//--- tb/gateway_timestamp_read_responder_test.sv
// Self-checking bench for the timestamp-read responder
`timescale 1ns/100ps
`default_nettype none
module gateway_timestamp_read_responder_test;
  // ==========================================
  // Signals
  logic sys_clk = 1'b0; // 50 MHz clock
  logic rst_b = 1'b0; // Async reset, active low
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, reqValid, reqReplyWanted, reqReady, replyValid, replyReady;
  logic [63:0] wallNow = 64'hFFFF_FFFF_FFFF_F000; // Starts near wrap
  logic [255:0] reqPayload, replyData;
  logic [31:0] replyByteEn, rd;
  logic ok, err;
  int n_errors = 0, check_count = 0;
  typedef struct {logic up; logic [63:0] ctx; int stall;} row_t;
  row_t rows[4] = '{'{1'b0, 64'h0, 0}, '{1'b1, 64'h0000_0FFF_FFFF_F123, 3},
    '{1'b0, 64'hFFFF_FFFF_FFFF_FFFF, 1}, '{1'b1, 64'h0123_4567_89AB_CDEF, 5}};
  logic [43:0] c1; // First context lap seen while running
  int t1; // Its take cycle
  // Clock and a free-running device timestamp
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) wallNow <= wallNow + 64'd80;
  // ==========================================
  // Instances
  ts_read_responder dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wallclockIn(wallNow), .reqValid(reqValid), .reqPayload(reqPayload),
    .reqReplyWanted(reqReplyWanted), .reqReady(reqReady), .replyValid(replyValid),
    .replyData(replyData), .replyByteEn(replyByteEn), .replyReady(replyReady));
  thread_model partner_u (.sys_clk(sys_clk), .reqReady(reqReady), .replyValid(replyValid),
    .replyData(replyData), .replyByteEn(replyByteEn), .wallclockIn(wallNow), .reqValid(reqValid),
    .reqPayload(reqPayload), .reqReplyWanted(reqReplyWanted), .replyReady(replyReady));
  // ==========================================
  // Helpers
  task automatic check(input string what, input logic [287:0] seen, input logic [287:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check
  // Expected reply: enables above the image
  function automatic logic [287:0] expect_reply(input logic [63:0] w, input logic [63:0] c, input logic up);
    logic [127:0] h;
    h = {c[43:12], c[11:0], 20'h0_0000, w[43:12], w[11:0], 20'h0_0000};
    return up ? {32'hFFFF_0000, h, 128'h0} : {32'h0000_FFFF, 128'h0, h};
  endfunction : expect_reply
  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(what, {err, rd}, {1'b0, exp});
  endtask : rdchk
  // Load a context lap with counting stopped
  task automatic set_ctx(input logic [63:0] v);
    apb(1'b1, ts_reply_pkg::REG_SAVE_LO, v[31:0]);
    apb(1'b1, ts_reply_pkg::REG_SAVE_HI, v[63:32]);
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0004);
  endtask : set_ctx
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // Watchdog, well past the expected few hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    $display("mismatch watchdog expected done seen hang");
    n_errors++;
    end_of_test();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rdchk("control", ts_reply_pkg::REG_CONTROL, 32'h0000_0000);
    rdchk("save_hi", ts_reply_pkg::REG_SAVE_HI, 32'h0000_0000);
    apb(1'b1, ts_reply_pkg::REG_STATUS, 32'hFFFF_FFFF);
    rdchk("status", ts_reply_pkg::REG_STATUS, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", {err, rd}, {1'b1, 32'h0000_0000});
    $display("test registers done");
    // Table of ordinary replies
    foreach (rows[i])
    begin
      set_ctx(rows[i].ctx);
      partner_u.send(rows[i].up, 1'b1, rows[i].stall, ok);
      check("reply", {partner_u.gotEn, partner_u.gotData},
        expect_reply(partner_u.takeWall, rows[i].ctx, rows[i].up));
      check("flow", {ok, partner_u.gotReply, partner_u.busyLeak}, 3'b110);
      @(posedge sys_clk);
      check("ready", reqReady, 1'b1);
    end
    $display("test table done");
    // Save picks up the live lap over a software write, restore brings it back
    set_ctx(64'h0000_0ABC_DEF0_1234);
    apb(1'b1, ts_reply_pkg::REG_SAVE_LO, 32'h1111_1111);
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0002);
    rdchk("saved_lo", ts_reply_pkg::REG_SAVE_LO, 32'hDEF0_1234);
    rdchk("saved_hi", ts_reply_pkg::REG_SAVE_HI, 32'h0000_0ABC);
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0004);
    partner_u.send(1'b0, 1'b1, 0, ok);
    check("restored", {partner_u.gotEn, partner_u.gotData},
      expect_reply(partner_u.takeWall, 64'h0000_0ABC_DEF0_1234, 1'b0));
    $display("test save_restore done");
    // Running lap started just below the 64-bit wrap, which it passes before the first request; back-to-back requests
    set_ctx(64'hFFFF_FFFF_FFFF_FFC0);
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0001);
    partner_u.send(1'b0, 1'b1, 0, ok);
    c1 = {partner_u.gotData[127:96], partner_u.gotData[95:84]};
    t1 = partner_u.takeCycle;
    partner_u.send(1'b0, 1'b1, 2, ok);
    check("ctx_step", {partner_u.gotData[127:96], partner_u.gotData[95:84]} - c1,
      44'(80 * (partner_u.takeCycle - t1)));
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0000);
    $display("test running done");
    // No reply flag: nothing comes back, drop is counted
    partner_u.send(1'b1, 1'b0, 0, ok);
    check("dropped", {ok, partner_u.gotReply, reqReady}, 3'b101);
    rdchk("counts", ts_reply_pkg::REG_STATUS, 32'h0007_0100);
    $display("test drop done");
    // Reset in mid-run clears outputs and registers
    apb(1'b1, ts_reply_pkg::REG_CONTROL, 32'h0000_0001);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("in_reset", {reqReady, replyValid, pready}, 3'b000);
    rst_b <= 1'b1;
    rdchk("control_again", ts_reply_pkg::REG_CONTROL, 32'h0000_0000);
    rdchk("status_again", ts_reply_pkg::REG_STATUS, 32'h0000_0000);
    $display("test reset done");
    end_of_test();
  end
endmodule : gateway_timestamp_read_responder_test
`default_nettype wire
